// ===== rtl/tcu_pkg.sv
package tcu_pkg;

  localparam int unsigned NCH      = 8;
  localparam int unsigned CNT_W    = 16;
  localparam int unsigned CLK_MHZ  = 200;

  // Register byte offsets on the APB side.
  localparam logic [7:0] ADR_CTRL_ONE  = 8'h00;
  localparam logic [7:0] ADR_CTRL_TWO  = 8'h04;
  localparam logic [7:0] ADR_PREC_VAL  = 8'h08;
  localparam logic [7:0] ADR_IO_SEL    = 8'h0c;
  localparam logic [7:0] ADR_OUT_MODE  = 8'h10;
  localparam logic [7:0] ADR_OUT_LEVEL = 8'h14;
  localparam logic [7:0] ADR_PIN_DISC  = 8'h18;
  localparam logic [7:0] ADR_FORCE     = 8'h1c;
  localparam logic [7:0] ADR_CH7_MASK  = 8'h20;
  localparam logic [7:0] ADR_CH7_DATA  = 8'h24;
  localparam logic [7:0] ADR_OVF_TOG   = 8'h28;
  localparam logic [7:0] ADR_EDGE_CFG  = 8'h2c;
  localparam logic [7:0] ADR_STATUS    = 8'h30;
  localparam logic [7:0] ADR_INT_MASK  = 8'h34;
  localparam logic [7:0] ADR_COUNTER   = 8'h38;
  localparam logic [7:0] ADR_CHAN_BASE = 8'h40;
  localparam logic [2:0] CHAN_PAGE     = 3'h2;

  // Field positions.
  localparam int unsigned CTL1_TEN  = 0;
  localparam int unsigned CTL1_PRECISION_PRESCALE_ENABLE = 1;
  localparam int unsigned CTL1_PULSE_ACCUMULATOR_ENABLE = 2;
  localparam int unsigned CTL2_COUNTER_RESET_ON_CH7_MATCH = 3;
  localparam int unsigned STAT_OVF  = 8;

  // Reset values and the counter maximum.
  localparam logic [7:0]       RST_BYTE  = 8'h00;
  localparam logic [15:0]      RST_HALF  = 16'h0000;
  localparam logic [2:0]       RST_PRSEL = 3'h0;
  localparam logic [CNT_W-1:0] CNT_MAX   = 16'hffff;

  typedef enum logic [1:0] {
    TCU_EDGE_OFF  = 2'b00,
    TCU_EDGE_RISE = 2'b01,
    TCU_EDGE_FALL = 2'b10,
    TCU_EDGE_ANY  = 2'b11
  } tcu_edge_t;

endpackage : tcu_pkg

// ===== rtl/tcu_prescaler.sv
`timescale 1ns/100ps
`default_nettype none
module tcu_prescaler
  import tcu_pkg::*;
(
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Control
  input  wire logic       enable,
  input  wire logic       precision_prescale_enable,
  input  wire logic [2:0] prescale_select,
  input  wire logic [7:0] precision_prescale_value,
  // Tick out
  output logic            tick
);

  logic [7:0] div_cnt_r;
  logic [7:0] limit;

  // A divisor of N counts from 0 to N-1, so the value field holds N-1.
  always_comb begin
    if (precision_prescale_enable) begin
      limit = precision_prescale_value;
    end else begin
      limit = 8'((9'h001 << prescale_select) - 9'h001);
    end
  end

  assign tick = enable && (div_cnt_r >= limit);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt_r <= RST_BYTE;
    end else if (!enable || tick) begin
      div_cnt_r <= RST_BYTE;
    end else begin
      div_cnt_r <= div_cnt_r + 8'h01;
    end
  end

endmodule : tcu_prescaler
`default_nettype wire

// ===== rtl/tcu_edge_det.sv
`timescale 1ns/100ps
`default_nettype none
module tcu_edge_det
  import tcu_pkg::*;
(
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // Pins and per-channel edge choice
  input  wire logic [NCH-1:0]    pin,
  input  wire logic [2*NCH-1:0]  edge_cfg,
  // One-cycle edge pulses
  output logic      [NCH-1:0]    hit
);

  logic [NCH-1:0] prev_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_r <= RST_BYTE;
    end else begin
      prev_r <= pin;
    end
  end

  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      unique case (tcu_edge_t'(edge_cfg[2*i +: 2]))
        TCU_EDGE_OFF:  hit[i] = 1'b0;
        TCU_EDGE_RISE: hit[i] = pin[i] && !prev_r[i];
        TCU_EDGE_FALL: hit[i] = !pin[i] && prev_r[i];
        TCU_EDGE_ANY:  hit[i] = pin[i] != prev_r[i];
      endcase
    end
  end

endmodule : tcu_edge_det
`default_nettype wire

// ===== rtl/tcu_top.sv
// Operation
// R1 - Prescale select divides by power of two.
// R2 - Precision enable divides by value plus one.
// R3 - Input capture copies counter on active edge.
// R4 - Capture pulses last over two bus clocks.
// R5 - Capture sets flag; interrupt only when enabled.
// R6 - Flag cleared by one, timer enabled. The code also clears it when only the accumulator is enabled.
// R7 - Compare match acts on pin unless disconnected.
// R8 - Compare match sets flag; enabled interrupt.
// R9 - Mode and level choose set/clear/toggle/none.
// R10 - Force compare acts now, flag untouched.
// R11 - Channel 7 event overrides other compares.
// R12 - Channel 7 data applied through mask.
// R13 - Channel 7 match may reset counter.
// R14 - Free-running 16-bit counter on prescaled tick.
`timescale 1ns/100ps
`default_nettype none
module tcu_top
  import tcu_pkg::*;
(
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // APB slave
  input  wire logic [7:0]        paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Channel pins
  input  wire logic [NCH-1:0]    ch_pin_in,
  output logic      [NCH-1:0]    ch_pin_out,
  output logic      [NCH-1:0]    ch_pin_oe_n,
  // Interrupt
  output logic                   irq
);

  // Control registers.
  logic             timer_enable_r;
  logic             precision_prescale_enable_r;
  logic             pulse_accumulator_enable_r;
  logic [2:0]       prescale_select_r;
  logic             counter_reset_on_ch7_match_r;
  logic [7:0]       precision_prescale_value_r;
  logic [NCH-1:0]   channel_io_select_r;
  logic [NCH-1:0]   output_mode_bit_r;
  logic [NCH-1:0]   output_level_bit_r;
  logic [NCH-1:0]   compare_pin_disconnect_r;
  logic [NCH-1:0]   ch7_mask_r;
  logic [NCH-1:0]   ch7_data_r;
  logic [NCH-1:0]   overflow_toggle_enable_r;
  logic [2*NCH-1:0] edge_cfg_r;
  logic [NCH:0]     int_mask_r;

  // Status and state.
  logic [NCH-1:0]   channel_event_flag_r;
  logic             overflow_flag_r;
  logic [CNT_W-1:0] counter_r;
  logic [CNT_W-1:0] channel_capture_compare_value_r [NCH];

  // Registered outputs to the bus, the pins and the interrupt.
  logic [31:0]      prdata_r;
  logic             pready_r;
  logic             pslverr_r;
  logic [NCH-1:0]   pin_out_r;
  logic [NCH-1:0]   pin_oe_n_r;
  logic             irq_r;

  logic             tick;
  logic [NCH-1:0]   edge_hit;
  logic [NCH-1:0]   capture_hit;
  logic [NCH-1:0]   compare_hit;
  logic             overflow;
  logic             ch7_event;
  logic             apb_setup;
  logic             apb_wr;
  logic             chan_sel;
  logic [2:0]       chan_idx;
  logic             addr_ok;
  logic [NCH-1:0]   force_compare;
  logic [NCH-1:0]   flag_clear;
  logic             ovf_clear;
  logic             clear_ok;
  logic [NCH-1:0]   oc_drive;
  logic [NCH-1:0]   ch7_override;

  function automatic logic oc_action(input logic om, input logic ol, input logic cur);
    logic res;
    res = cur;
    unique case ({om, ol})
      2'b00: res = cur;
      2'b01: res = !cur;
      2'b10: res = 1'b0;
      2'b11: res = 1'b1;
    endcase
    return res;
  endfunction : oc_action

  function automatic logic [31:0] pad8(input logic [7:0] v);
    return {24'h000000, v};
  endfunction : pad8

  tcu_prescaler u_prescaler (
    .pclk                      (pclk),
    .presetn                   (presetn),
    .enable                    (timer_enable_r),
    .precision_prescale_enable (precision_prescale_enable_r),  // [R2]
    .prescale_select           (prescale_select_r),            // [R1]
    .precision_prescale_value  (precision_prescale_value_r),
    .tick                      (tick)
  );

  // Pins are taken as synchronous; a pulse lasting one clock is enough to be seen.
  tcu_edge_det u_edge_det (
    .pclk     (pclk),
    .presetn  (presetn),
    .pin      (ch_pin_in),  // [R4]
    .edge_cfg (edge_cfg_r),
    .hit      (edge_hit)
  );

  // APB decode: read data is latched in the setup cycle, so every access
  // completes with no wait state and prdata can come from a flip-flop.
  assign apb_setup = psel && !penable;
  assign apb_wr    = psel && penable && pwrite && pready_r && !pslverr_r;
  assign chan_sel  = paddr[7:5] == CHAN_PAGE;
  assign chan_idx  = paddr[4:2];

  always_comb begin
    unique case (paddr)
      ADR_CTRL_ONE, ADR_CTRL_TWO, ADR_PREC_VAL, ADR_IO_SEL, ADR_OUT_MODE,
      ADR_OUT_LEVEL, ADR_PIN_DISC, ADR_FORCE, ADR_CH7_MASK, ADR_CH7_DATA,
      ADR_OVF_TOG, ADR_EDGE_CFG, ADR_STATUS, ADR_INT_MASK,
      ADR_COUNTER: addr_ok = 1'b1;
      default:     addr_ok = chan_sel && (paddr[1:0] == 2'b00);
    endcase
  end

  // A forced compare reaches the pin logic only, so it never sets a flag.
  assign force_compare = (apb_wr && paddr == ADR_FORCE) ? pwdata[NCH-1:0] : RST_BYTE;

  // A clear is honoured only while the timer or the accumulator is enabled.
  assign clear_ok   = timer_enable_r || pulse_accumulator_enable_r;
  assign flag_clear = (apb_wr && paddr == ADR_STATUS && clear_ok)
                      ? pwdata[NCH-1:0] : RST_BYTE;  // [R6]
  assign ovf_clear  = apb_wr && paddr == ADR_STATUS && pwdata[STAT_OVF] && clear_ok;

  // Events are evaluated on the tick that ends the counter's current value.
  assign overflow = tick && (counter_r == CNT_MAX);
  // Captures need a running timer; a stopped timer keeps the value software wrote.
  assign capture_hit = edge_hit & ~channel_io_select_r & {NCH{timer_enable_r}};  // [R3]
  // A match needs a tick, so a slow counter does not flag one value every clock.
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      compare_hit[i] = tick && channel_io_select_r[i] &&
                       (counter_r == channel_capture_compare_value_r[i]);  // [R7]
    end
  end
  assign ch7_event = compare_hit[NCH-1] || (overflow && overflow_toggle_enable_r[NCH-1]);  // [R11]

  // Channel 7 never overrides itself; its own action comes from its own match.
  always_comb begin
    ch7_override = RST_BYTE;
    for (int i = 0; i < NCH-1; i++) begin
      ch7_override[i] = ch7_event && ch7_mask_r[i];  // [R11] [R12]
    end
  end

  // Only compare channels that are not disconnected own their pin.
  assign oc_drive = channel_io_select_r & ~compare_pin_disconnect_r;  // [R7]

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r  <= 32'h00000000;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      pready_r  <= apb_setup;
      pslverr_r <= apb_setup && !addr_ok;
      if (apb_setup) begin
        prdata_r <= 32'h00000000;
        // A misaligned channel address reads zero along with its error.
        if (chan_sel && addr_ok) begin
          prdata_r <= {16'h0000, channel_capture_compare_value_r[chan_idx]};
        end else begin
          unique case (paddr)
            ADR_CTRL_ONE:  prdata_r <= {29'h00000000, pulse_accumulator_enable_r,
                                        precision_prescale_enable_r, timer_enable_r};
            ADR_CTRL_TWO:  prdata_r <= {28'h0000000, counter_reset_on_ch7_match_r,
                                        prescale_select_r};
            ADR_PREC_VAL:  prdata_r <= pad8(precision_prescale_value_r);
            ADR_IO_SEL:    prdata_r <= pad8(channel_io_select_r);
            ADR_OUT_MODE:  prdata_r <= pad8(output_mode_bit_r);
            ADR_OUT_LEVEL: prdata_r <= pad8(output_level_bit_r);
            ADR_PIN_DISC:  prdata_r <= pad8(compare_pin_disconnect_r);
            ADR_CH7_MASK:  prdata_r <= pad8(ch7_mask_r);
            ADR_CH7_DATA:  prdata_r <= pad8(ch7_data_r);
            ADR_OVF_TOG:   prdata_r <= pad8(overflow_toggle_enable_r);
            ADR_EDGE_CFG:  prdata_r <= {16'h0000, edge_cfg_r};
            ADR_STATUS:    prdata_r <= {23'h000000, overflow_flag_r, channel_event_flag_r};
            ADR_INT_MASK:  prdata_r <= {23'h000000, int_mask_r};
            ADR_COUNTER:   prdata_r <= {16'h0000, counter_r};
            default:       prdata_r <= 32'h00000000;
          endcase
        end
      end
    end
  end

  // Software-written configuration.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_enable_r               <= 1'b0;
      precision_prescale_enable_r  <= 1'b0;
      pulse_accumulator_enable_r   <= 1'b0;
      prescale_select_r            <= RST_PRSEL;
      counter_reset_on_ch7_match_r <= 1'b0;
      precision_prescale_value_r   <= RST_BYTE;
      channel_io_select_r          <= RST_BYTE;
      output_mode_bit_r            <= RST_BYTE;
      output_level_bit_r           <= RST_BYTE;
      compare_pin_disconnect_r     <= RST_BYTE;
      ch7_mask_r                   <= RST_BYTE;
      ch7_data_r                   <= RST_BYTE;
      overflow_toggle_enable_r     <= RST_BYTE;
      edge_cfg_r                   <= RST_HALF;
      int_mask_r                   <= 9'h000;
    end else if (apb_wr) begin
      unique case (paddr)
        ADR_CTRL_ONE: begin
          timer_enable_r              <= pwdata[CTL1_TEN];
          precision_prescale_enable_r <= pwdata[CTL1_PRECISION_PRESCALE_ENABLE];
          pulse_accumulator_enable_r  <= pwdata[CTL1_PULSE_ACCUMULATOR_ENABLE];
        end
        ADR_CTRL_TWO: begin
          prescale_select_r            <= pwdata[2:0];
          counter_reset_on_ch7_match_r <= pwdata[CTL2_COUNTER_RESET_ON_CH7_MATCH];
        end
        ADR_PREC_VAL:  precision_prescale_value_r <= pwdata[7:0];
        ADR_IO_SEL:    channel_io_select_r        <= pwdata[NCH-1:0];
        ADR_OUT_MODE:  output_mode_bit_r          <= pwdata[NCH-1:0];
        ADR_OUT_LEVEL: output_level_bit_r         <= pwdata[NCH-1:0];
        ADR_PIN_DISC:  compare_pin_disconnect_r   <= pwdata[NCH-1:0];
        ADR_CH7_MASK:  ch7_mask_r                 <= pwdata[NCH-1:0];
        ADR_CH7_DATA:  ch7_data_r                 <= pwdata[NCH-1:0];
        ADR_OVF_TOG:   overflow_toggle_enable_r   <= pwdata[NCH-1:0];
        ADR_EDGE_CFG:  edge_cfg_r                 <= pwdata[2*NCH-1:0];
        ADR_INT_MASK:  int_mask_r                 <= pwdata[NCH:0];
        default: ;
      endcase
    end
  end

  // Main counter.
  // A reset by match lands on the tick, so the counter runs 0 to the channel 7 value.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      counter_r <= RST_HALF;
    end else if (tick) begin
      if (counter_reset_on_ch7_match_r && compare_hit[NCH-1]) begin
        counter_r <= RST_HALF;  // [R13]
      end else begin
        counter_r <= counter_r + 16'h0001;  // [R14]
      end
    end
  end

  // Channel value registers; a capture wins over a software write.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NCH; i++) begin
        channel_capture_compare_value_r[i] <= RST_HALF;
      end
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (capture_hit[i]) begin
          channel_capture_compare_value_r[i] <= counter_r;  // [R3]
        end else if (apb_wr && chan_sel && chan_idx == 3'(i)) begin
          channel_capture_compare_value_r[i] <= pwdata[CNT_W-1:0];
        end
      end
    end
  end

  // Sticky flags: a new event in the cycle of its clear keeps the flag set.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      channel_event_flag_r <= RST_BYTE;
      overflow_flag_r      <= 1'b0;
    end else begin
      channel_event_flag_r <= (channel_event_flag_r & ~flag_clear)
                              | capture_hit   // [R5]
                              | compare_hit;  // [R8]
      overflow_flag_r      <= (overflow_flag_r && !ovf_clear) || overflow;
    end
  end

  // The interrupt is registered and so follows its flag by one clock.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |({overflow_flag_r, channel_event_flag_r} & int_mask_r);  // [R5] [R8]
    end
  end

  // Pin drive. Later assignments take priority: overflow toggle, then match
  // or force, then the channel 7 override on the other channels.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out_r  <= RST_BYTE;
      pin_oe_n_r <= 8'hff;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        pin_oe_n_r[i] <= !oc_drive[i];
        // Released pins are not updated, so they keep their last level.
        if (oc_drive[i]) begin
          if (overflow && overflow_toggle_enable_r[i]) begin
            pin_out_r[i] <= !pin_out_r[i];
          end
          if (compare_hit[i] || force_compare[i]) begin
            pin_out_r[i] <= oc_action(output_mode_bit_r[i], output_level_bit_r[i],
                                      pin_out_r[i]);  // [R7] [R9] [R10]
          end
          if (ch7_override[i]) begin
            pin_out_r[i] <= ch7_data_r[i];  // [R11] [R12]
          end
        end
      end
    end
  end

  assign prdata      = prdata_r;
  assign pready      = pready_r;
  assign pslverr     = pslverr_r;
  assign ch_pin_out  = pin_out_r;
  assign ch_pin_oe_n = pin_oe_n_r;
  assign irq         = irq_r;

endmodule : tcu_top
`default_nettype wire

// ===== verification/tcu_checker.sv
`timescale 1ns/100ps
`default_nettype none
module tcu_checker
  import tcu_pkg::*;
(
  // Clock and reset
  input wire logic           pclk,
  input wire logic           presetn,
  // APB
  input wire logic           psel,
  input wire logic           penable,
  input wire logic           pwrite,
  input wire logic [31:0]    prdata,
  input wire logic           pready,
  input wire logic           pslverr,
  // Pins and interrupt
  input wire logic [NCH-1:0] ch_pin_out,
  input wire logic [NCH-1:0] ch_pin_oe_n,
  input wire logic           irq
);
  wire logic setup_c = psel & ~penable;
  wire logic wr_acc  = psel & penable & pwrite;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  chk_ready_setup: assert property (setup_c |=> pready)
    else $error("no ready after setup");
  chk_ready_once: assert property (pready |=> !pready)
    else $error("ready held too long");
  chk_ready_cause: assert property (pready |-> $past(setup_c))
    else $error("ready without setup");
  chk_err_data: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("bad error response");
  chk_err_once: assert property (pslverr |=> !pslverr)
    else $error("error held too long");
  chk_oe_write: assert property ($changed(ch_pin_oe_n) |-> $past(wr_acc) || $past(wr_acc, 2))
    else $error("pin enable moved without write");
  chk_disc_hold: assert property (((ch_pin_out ^ $past(ch_pin_out)) & ch_pin_oe_n
    & $past(ch_pin_oe_n)) == '0)
    else $error("released pin changed level");
  chk_irq_fall: assert property ($fell(irq) |-> $past(wr_acc) || $past(wr_acc, 2))
    else $error("interrupt dropped without write");

  cov_irq: cover property ($rose(irq));
  cov_err: cover property (pslverr);
  cov_drive: cover property ($fell(ch_pin_oe_n[0]));
endmodule : tcu_checker

bind tcu_top tcu_checker tcu_checker_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .ch_pin_out(ch_pin_out), .ch_pin_oe_n(ch_pin_oe_n), .irq(irq));
`default_nettype wire

// ===== verification/tcu_pin_model.sv
`timescale 1ns/100ps
`default_nettype none
module tcu_pin_model
  import tcu_pkg::*;
(
  // Clock
  input  wire logic           pclk,
  // Device side of the pins
  input  wire logic [NCH-1:0] ch_pin_out,
  input  wire logic [NCH-1:0] ch_pin_oe_n,
  output logic      [NCH-1:0] ch_pin_in
);
  logic [NCH-1:0] src_r;

  initial src_r = '0;
  // A driven pin shows the device level, a released one the event source.
  assign ch_pin_in = (ch_pin_out & ~ch_pin_oe_n) | (src_r & ch_pin_oe_n);

  // Four cycles keeps the pulse well above the minimum so no edge is lost.
  task automatic pulse(input int unsigned ch);
    @(posedge pclk);
    src_r[ch] <= 1'b1;
    repeat (4) @(posedge pclk);
    src_r[ch] <= 1'b0;
  endtask : pulse
endmodule : tcu_pin_model
`default_nettype wire

// ===== verification/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench
  import tcu_pkg::*;
;
  logic           pclk;
  logic           presetn;
  logic [7:0]     paddr;
  logic           psel;
  logic           penable;
  logic           pwrite;
  logic [31:0]    pwdata;
  logic [31:0]    prdata;
  logic           pready;
  logic           pslverr;
  logic [NCH-1:0] ch_pin_in;
  logic [NCH-1:0] ch_pin_out;
  logic [NCH-1:0] ch_pin_oe_n;
  logic           irq;
  int             n_fail = 0;
  int             n_compared = 0;
  int             cycles = 0;
  int             dv;
  logic [31:0]    rd_d;
  logic           err_d;
  logic [31:0]    c1;
  logic [31:0]    c2;
  logic [4:0]     p;
  logic [7:0]     pv [3] = '{8'h00, 8'h04, 8'hff};

  tcu_top tcu_top_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ch_pin_in(ch_pin_in), .ch_pin_out(ch_pin_out),
    .ch_pin_oe_n(ch_pin_oe_n), .irq(irq));
  tcu_pin_model tcu_pin_model_inst (.pclk(pclk), .ch_pin_out(ch_pin_out),
    .ch_pin_oe_n(ch_pin_oe_n), .ch_pin_in(ch_pin_in));

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  task automatic close_out();
    $display("Compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : close_out

  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      n_fail = n_fail + 1;
      close_out();
    end
  end

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_compared = n_compared + 1;
    if (got !== exp) begin
      n_fail = n_fail + 1;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd_d = prdata;
    err_d = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    cmp(rd_d, exp);
  endtask : rd

  initial begin
    presetn = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd(ADR_STATUS, 32'h0);
    rd(ADR_COUNTER, 32'h0);
    apb(1'b0, 8'hfc, 32'h0);
    cmp({31'h0, err_d}, 32'h1);
    cmp(rd_d, 32'h0);
    // Any window that is a whole multiple of the divisor holds a fixed tick count.
    for (int i = 0; i < 11; i++) begin
      dv = (i < 8) ? (1 << i) : pv[i-8] + 1;
      wr(ADR_CTRL_TWO, 32'(i % 8));
      wr(ADR_PREC_VAL, (i < 8) ? 32'h0 : 32'(pv[i-8]));
      wr(ADR_CTRL_ONE, (i < 8) ? 32'h1 : 32'h3);
      repeat (300) @(posedge pclk);
      apb(1'b0, ADR_COUNTER, 32'h0);
      c1 = rd_d;
      repeat (4 * dv - 3) @(posedge pclk);
      apb(1'b0, ADR_COUNTER, 32'h0);
      cmp(32'(rd_d[15:0] - c1[15:0]), 32'h4);
    end
    // Channel 2 captures on a rising edge, channel 3 on a falling one.
    wr(ADR_EDGE_CFG, 32'h90);
    apb(1'b0, ADR_COUNTER, 32'h0);
    c1 = rd_d;
    tcu_pin_model_inst.pulse(2);
    tcu_pin_model_inst.pulse(3);
    apb(1'b0, ADR_COUNTER, 32'h0);
    c2 = rd_d;
    apb(1'b0, ADR_CHAN_BASE + 8'h08, 32'h0);
    cmp(32'(rd_d >= c1 && rd_d <= c2), 32'h1);
    apb(1'b0, ADR_CHAN_BASE + 8'h0c, 32'h0);
    cmp(32'(rd_d >= c1 && rd_d <= c2), 32'h1);
    rd(ADR_STATUS, 32'hc);
    cmp({31'h0, irq}, 32'h0);
    wr(ADR_INT_MASK, 32'h4);
    repeat (2) @(posedge pclk);
    cmp({31'h0, irq}, 32'h1);
    wr(ADR_CTRL_ONE, 32'h2);
    wr(ADR_STATUS, 32'hc);
    rd(ADR_STATUS, 32'hc);
    wr(ADR_CTRL_ONE, 32'h3);
    wr(ADR_STATUS, 32'hc);
    rd(ADR_STATUS, 32'h0);
    cmp({31'h0, irq}, 32'h0);
    // A second reset puts the counter back at zero so the compare period is known.
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd(ADR_COUNTER, 32'h0);
    wr(ADR_CTRL_TWO, 32'h8);
    wr(ADR_IO_SEL, 32'h9f);
    wr(ADR_OUT_MODE, 32'h1c);
    wr(ADR_OUT_LEVEL, 32'h1a);
    wr(ADR_PIN_DISC, 32'h10);
    wr(ADR_INT_MASK, 32'h80);
    for (int i = 0; i < 4; i++) wr(ADR_CHAN_BASE + 8'(4 * i), 32'd10);
    wr(ADR_CHAN_BASE + 8'h1c, 32'd31);
    apb(1'b0, ADR_CHAN_BASE + 8'h01, 32'h0);
    cmp({31'h0, err_d}, 32'h1);
    cmp(rd_d, 32'h0);
    wr(ADR_FORCE, 32'h0f);
    repeat (2) @(posedge pclk);
    cmp(32'(ch_pin_out[3:0]), 32'ha);
    cmp(32'(ch_pin_oe_n), 32'h70);
    rd(ADR_STATUS, 32'h0);
    wr(ADR_CTRL_ONE, 32'h1);
    repeat (40) @(posedge pclk);
    rd(ADR_STATUS, 32'h9f);
    cmp({31'h0, irq}, 32'h1);
    p = ch_pin_out[4:0];
    repeat (32) @(posedge pclk);
    cmp(32'(ch_pin_out[4:0]), 32'(p ^ 5'h02));
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, ADR_COUNTER, 32'h0);
      cmp(32'(rd_d <= 32'd31), 32'h1);
    end
    wr(ADR_CH7_MASK, 32'h0f);
    wr(ADR_CH7_DATA, 32'h05);
    for (int i = 0; i < 4; i++) wr(ADR_CHAN_BASE + 8'(4 * i), 32'd31);
    repeat (70) @(posedge pclk);
    cmp(32'(ch_pin_out[3:0]), 32'h5);
    repeat (32) @(posedge pclk);
    cmp(32'(ch_pin_out[3:0]), 32'h5);
    // Without the match reset the counter wraps once; only the overflow makes a channel 7 event.
    wr(ADR_CTRL_TWO, 32'h0);
    wr(ADR_IO_SEL, 32'h1f);
    wr(ADR_OUT_MODE, 32'h0);
    wr(ADR_OUT_LEVEL, 32'h0);
    wr(ADR_OVF_TOG, 32'h80);
    wr(ADR_CH7_DATA, 32'h0a);
    wr(ADR_INT_MASK, 32'h100);
    wr(ADR_STATUS, 32'h1ff);
    repeat (66000) @(posedge pclk);
    cmp(32'(ch_pin_out[3:0]), 32'ha);
    rd(ADR_STATUS, 32'h11f);
    cmp({31'h0, irq}, 32'h1);
    close_out();
  end
endmodule : testbench
`default_nettype wire
